// File: core/baseband_ctl.sv
// Baseband processor end: APB registers, device register proxy and the
// link bring-up sequence (CGS, deframer reset, SYSREF, delay, ILAS, data).
// Assumes an APB master on pclk and the device end on the same clock.
`timescale 1ns/100ps
`include "dfr_regs.svh"
module baseband_ctl (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link to the device
	lane_link_if.host lnk,
	// Bring-up status
	output logic link_up
);
	dfr_pkg::host_state_t state;
	logic start;
	logic [3:0] inj;
	logic [21:0] px;
	logic pend;
	logic busy;
	logic [15:0] px_res;
	logic [31:0] ilas_w [0:3];
	logic [15:0] sof_delay;
	logic [15:0] rate;
	logic [15:0] cnt;
	logic [7:0] sum;
	logic c_wr;
	logic c_rd;
	logic [3:0] c_addr;
	logic [15:0] c_wdata;
	logic l_sref;
	logic l_valid;
	logic l_ilas;
	logic l_stb;
	logic [3:0] l_idx;
	logic [7:0] l_val;

	wire acc = psel & penable;
	wire wr_en = acc & pwrite;
	wire sel_ctrl = paddr == `H_CTRL;
	wire sel_px = paddr == `H_PROXY;
	wire sel_pxr = paddr == `H_PROXY_RD;
	wire sel_stat = paddr == `H_STAT;
	wire sel_dly = paddr == `H_DELAY;
	wire sel_rate = paddr == `H_RATE;
	wire sel_ilas = (paddr[7:4] == `H_ILAS_HI) && (paddr[1:0] == 2'b00);
	wire mapped = sel_ctrl | sel_px | sel_pxr | sel_stat | sel_dly | sel_rate | sel_ilas;
	wire rate_ok = (rate >= `RATE_MIN) && (rate <= `RATE_MAX);
	wire seq_wr = state == dfr_pkg::H_RESET;
	wire issue = pend & ~seq_wr;
	wire px_set = wr_en & sel_px & (pwdata[20] | pwdata[21]);
	wire [7:0] cur_byte = ilas_w[cnt[3:2]][{cnt[1:0], 3'b000} +: 8];
	wire [31:0] rd_mux;

	// APB answers in the first access cycle; bad offsets raise pslverr
	assign pready = acc;
	assign pslverr = acc & ~mapped;
	assign link_up = state == dfr_pkg::H_DATA;
	assign rd_mux =
		sel_ctrl ? {31'h00000000, start} :
		sel_px ? {10'h000, px} :
		sel_pxr ? {busy, 15'h0000, px_res} :
		sel_stat ? {27'h0000000, ~rate_ok, 1'b0, state} :
		sel_dly ? {16'h0000, sof_delay} :
		sel_rate ? {16'h0000, rate} :
		sel_ilas ? ilas_w[paddr[3:2]] : 32'h00000000;

	// Register file and proxy bookkeeping; a new request beats a same-cycle issue
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start <= 1'b0;
			inj <= 4'h0;
			px <= 22'h000000;
			pend <= 1'b0;
			busy <= 1'b0;
			px_res <= 16'h0000;
			sof_delay <= 16'h0000;
			rate <= 16'h0000;
			prdata <= 32'h00000000;
			for (int i = 0; i < 4; i++) ilas_w[i] <= 32'h00000000;
		end else begin
			if (psel && !penable) prdata <= rd_mux;
			inj <= (wr_en && sel_ctrl) ? pwdata[7:4] : 4'h0;
			if (wr_en && sel_ctrl) start <= pwdata[0];
			if (wr_en && sel_px) px <= pwdata[21:0];
			if (wr_en && sel_dly) sof_delay <= pwdata[15:0];
			if (wr_en && sel_rate) rate <= pwdata[15:0];
			if (wr_en && sel_ilas) ilas_w[paddr[3:2]] <= pwdata;
			pend <= px_set | (pend & ~issue);
			busy <= px_set | (busy & ~(issue & px[20]) & ~lnk.cfg_rvalid);
			if (lnk.cfg_rvalid) px_res <= lnk.cfg_rdata;
		end
	end

	// Bring-up sequencer; clearing start drops the link at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= dfr_pkg::H_IDLE;
			cnt <= 16'h0000;
		end else if (!start) begin
			state <= dfr_pkg::H_IDLE;
			cnt <= 16'h0000;
		end else begin
			cnt <= cnt + 16'h0001;
			unique case (state)
				dfr_pkg::H_IDLE: begin
					cnt <= 16'h0000;
					if (rate_ok) state <= dfr_pkg::H_SYNC;
				end
				dfr_pkg::H_SYNC: if (cnt == `SYNC_CYCLES) state <= dfr_pkg::H_RESET;
				dfr_pkg::H_RESET: begin
					cnt <= 16'h0000;
					state <= dfr_pkg::H_SREF;
				end
				dfr_pkg::H_SREF: if (cnt == `SREF_END) begin
					cnt <= 16'h0000;
					state <= dfr_pkg::H_DELAY;
				end
				dfr_pkg::H_DELAY: if (cnt >= sof_delay) begin
					cnt <= 16'h0000;
					state <= dfr_pkg::H_ILAS;
				end
				dfr_pkg::H_ILAS: if (cnt[3:0] == `ILAS_CK) state <= dfr_pkg::H_DATA;
				dfr_pkg::H_DATA: cnt <= 16'h0000;
				default: state <= dfr_pkg::H_IDLE;
			endcase
		end
	end

	// Link drive, registered; the reset write also opens the SYSREF gate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c_wr <= 1'b0;
			c_rd <= 1'b0;
			c_addr <= 4'h0;
			c_wdata <= 16'h0000;
			l_sref <= 1'b0;
			l_valid <= 1'b0;
			l_ilas <= 1'b0;
			l_stb <= 1'b0;
			l_idx <= 4'h0;
			l_val <= 8'h00;
			sum <= 8'h00;
		end else begin
			c_wr <= seq_wr | (issue & px[20]);
			c_rd <= issue & ~px[20];
			c_addr <= seq_wr ? `DEV_CMD : px[19:16];
			c_wdata <= seq_wr ? `CMD_BRINGUP : px[15:0];
			// The gap keeps the SYSREF edge clear of the deframer reset pulse
			l_sref <= (state == dfr_pkg::H_SREF) && (cnt >= `SREF_GAP);
			l_valid <= state == dfr_pkg::H_DATA;
			l_ilas <= state == dfr_pkg::H_ILAS;
			l_stb <= state == dfr_pkg::H_ILAS;
			l_idx <= cnt[3:0];
			l_val <= (cnt[3:0] == `ILAS_CK) ? sum : cur_byte;
			if (state == dfr_pkg::H_ILAS) sum <= (cnt[3:0] == 4'h0) ? cur_byte : sum + cur_byte;
		end
	end

	assign lnk.cfg_wr = c_wr;
	assign lnk.cfg_rd = c_rd;
	assign lnk.cfg_addr = c_addr;
	assign lnk.cfg_wdata = c_wdata;
	assign lnk.sysref = l_sref;
	assign lnk.lane_data_valid = l_valid;
	assign lnk.ilas_active = l_ilas;
	assign lnk.ilas_stb = l_stb;
	assign lnk.ilas_idx = l_idx;
	assign lnk.ilas_val = l_val;
	assign {lnk.err_prbs, lnk.err_eof, lnk.err_eomf, lnk.err_fs} = inj;
endmodule

// File: core/deframer_ctl.sv
// Device end: settings registers, SYSREF gate, multiframe counter,
// latency buffer accounting, status byte and ILAS field check.
// Assumes the link side is synchronous to pclk and obeys the bring-up order.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "dfr_regs.svh"
module deframer_ctl #(
	parameter int LAT_DEPTH = 32
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link from the baseband processor
	lane_link_if.dev lnk,
	// Deserializer settings
	output logic [3:0] lane_en,
	output logic [3:0] lane_inv,
	output logic [2:0] eq_level,
	// Housekeeping
	output logic lane_fifo_clear,
	output logic cfg_ok,
	output logic irq
);
	localparam logic [7:0] DEPTH = 8'(LAT_DEPTH);
	localparam logic [7:0] HALF = 8'(LAT_DEPTH / 2);

	logic [15:0] lane_r;
	logic [15:0] frame_r;
	logic [15:0] ids_r;
	logic [15:0] link_r;
	logic [15:0] rate_r;
	logic [15:0] hs_r;
	logic gate;
	logic rst_q;
	logic sref_q;
	logic [7:0] lmfc;
	logic [5:0] sticky;
	logic [14:0] mm;
	logic [7:0] sum;
	logic [7:0] fill;
	logic rd_on;
	logic [7:0] cnt_at_rd;
	logic ovf;
	logic udf;
	logic irq_q;
	logic [15:0] rdata;
	logic rvalid;
	logic [7:0] expect_v [0:13];
	logic [14:0] fld_bad;

	wire wr_any = lnk.cfg_wr;
	wire wr_cmd = wr_any && (lnk.cfg_addr == `DEV_CMD);
	wire [3:0] mask = lane_r[`F_MASK];
	wire [2:0] m = frame_r[`F_M];
	wire [5:0] k = frame_r[`F_K];
	wire [4:0] ofs = link_r[`F_OFS];
	wire [2:0] eq = lane_r[`F_EQ];
	wire [2:0] lane_cnt;
	wire [3:0] f_oct;
	wire [9:0] fk;
	wire [7:0] period;
	wire [8:0] cfg_err;
	wire sref_in;
	wire sref_edge;
	wire [5:0] set_vec;
	wire ck_hit;
	wire wr_lat;
	wire [15:0] mismatch;
	wire [7:0] status;
	wire [15:0] rd_mux;
	wire next_irq;

	// Derived link shape: lanes from the mask, octets per frame = 2M/L
	assign lane_cnt = 3'(mask[0]) + 3'(mask[1]) + 3'(mask[2]) + 3'(mask[3]);
	assign f_oct = (lane_cnt == 3'h1) ? {m, 1'b0} : (lane_cnt == 3'h2) ? {1'b0, m} : {2'b00, m[2:1]};
	assign fk = 10'(f_oct) * 10'(k);
	assign period = fk[9:2];

	// Configuration checks; bank and lane number widths hold their ranges
	assign cfg_err[0] = !((m == 3'h2) || (m == 3'h4));
	assign cfg_err[1] = !((lane_cnt == 3'h1) || (lane_cnt == 3'h2) || (lane_cnt == 3'h4));
	assign cfg_err[2] = eq > `EQ_MAX;
	assign cfg_err[3] = (k == 6'h00) || (k > `K_MAX);
	assign cfg_err[4] = (fk <= `FK_MIN) || (fk > `FK_MAX) || (fk[1:0] != 2'b00);
	assign cfg_err[5] = {1'b0, ofs} >= k;
	assign cfg_err[6] = (rate_r < `RATE_MIN) || (rate_r > `RATE_MAX);
	assign cfg_err[7] = hs_r > `HIGH_SPEED_SERIAL_CLOCK_MAX;
	assign cfg_err[8] = (rate_r == 16'h0000) || ((hs_r % rate_r) != 16'h0000);
	assign cfg_ok = cfg_err == 9'h000;

	// Register writes; reserved bits are masked so they read back as zero, except bit 5 of the link register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lane_r <= 16'h0000;
			frame_r <= 16'h0000;
			ids_r <= 16'h0000;
			link_r <= 16'h0000;
			rate_r <= 16'h0000;
			hs_r <= 16'h0000;
			gate <= 1'b0;
		end else if (wr_any) begin
			unique case (lnk.cfg_addr)
				`DEV_CMD: gate <= lnk.cfg_wdata[`CMD_GATE];
				`DEV_LANE: lane_r <= lnk.cfg_wdata & `LANE_WMASK;
				`DEV_FRAME: frame_r <= lnk.cfg_wdata & `FRAME_WMASK;
				`DEV_IDS: ids_r <= lnk.cfg_wdata & `IDS_WMASK;
				`DEV_LINK: link_r <= lnk.cfg_wdata & `LINK_WMASK;
				`DEV_RATE: rate_r <= lnk.cfg_wdata;
				`DEV_HIGH_SPEED_SERIAL_CLOCK: hs_r <= lnk.cfg_wdata;
				default: ;
			endcase
		end
	end

	assign lane_en = mask;
	assign lane_inv = lane_r[`F_INV];
	assign eq_level = eq;

	// Deframer reset pulse, one cycle after the command write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_q <= 1'b0;
		end else begin
			rst_q <= wr_cmd && lnk.cfg_wdata[`CMD_RESET];
		end
	end
	assign lane_fifo_clear = rst_q;

	// SYSREF gate and edge; the edge realigns the multiframe counter
	assign sref_in = lnk.sysref & gate;
	assign sref_edge = sref_in & ~sref_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sref_q <= 1'b0;
			lmfc <= 8'h00;
		end else begin
			sref_q <= sref_in;
			if (sref_edge) begin
				lmfc <= 8'(ofs);
			end else if (rst_q || (lmfc >= period - 8'h01)) begin
				lmfc <= 8'h00;
			end else begin
				lmfc <= lmfc + 8'h01;
			end
		end
	end

	// Sticky status: {sysref seen, prbs, checksum ok, eof, eomf, frame_symbol_loss_flag}
	assign ck_hit = lnk.ilas_stb && (lnk.ilas_idx == `ILAS_CK);
	assign set_vec[5] = sref_edge;
	assign set_vec[4] = lnk.err_prbs;
	assign set_vec[3] = ck_hit && (lnk.ilas_val == sum);
	assign set_vec[2] = lnk.err_eof && lnk.ilas_active;
	assign set_vec[1] = lnk.err_eomf && lnk.ilas_active;
	assign set_vec[0] = lnk.err_fs;

	// A set arriving with the reset still wins, so no event is lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sticky <= 6'h00;
			mm <= 15'h0000;
		end else begin
			sticky <= (sticky & {6{~rst_q}}) | set_vec;
			mm <= (mm & {15{~rst_q}}) | fld_bad;
		end
	end

	// Expected ILAS fields from the programmed settings
	assign expect_v[0] = ids_r[`F_DID];
	assign expect_v[1] = {4'h0, ids_r[`F_BID]};
	assign expect_v[2] = {3'h0, link_r[`F_LID]};
	assign expect_v[3] = 8'(lane_cnt - 3'h1);
	assign expect_v[4] = {7'h00, link_r[`F_SCR]};
	assign expect_v[5] = 8'(f_oct - 4'h1);
	assign expect_v[6] = 8'(k - 6'h01);
	assign expect_v[7] = 8'(m - 3'h1);
	assign expect_v[8] = `ILAS_NM1;
	assign expect_v[9] = 8'h00;
	assign expect_v[10] = `ILAS_NPM1;
	assign expect_v[11] = 8'h00;
	assign expect_v[12] = 8'h00;
	assign expect_v[13] = {7'h00, (m == 3'h2) && (lane_cnt == 3'h4)};

	// Per-field compare as each ILAS field strobes in
	for (genvar i = 0; i < 14; i++) begin : g_fld
		assign fld_bad[i] = lnk.ilas_stb && (lnk.ilas_idx == 4'(i)) && (lnk.ilas_val != expect_v[i]);
	end
	assign fld_bad[14] = ck_hit && (lnk.ilas_val != sum);
	assign mismatch = {|mm, mm};

	// Running checksum over fields 0..13
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sum <= 8'h00;
		end else if (lnk.ilas_stb && (lnk.ilas_idx < `ILAS_CK)) begin
			sum <= (lnk.ilas_idx == 4'h0) ? lnk.ilas_val : sum + lnk.ilas_val;
		end
	end

	// Latency buffer: fills once SYSREF is seen, drains from half full
	assign wr_lat = lnk.lane_data_valid && sticky[5];
	wire ovf_set = wr_lat && !rd_on && (fill == DEPTH); // A fault in the reset cycle still shows
	wire udf_set = rd_on && !wr_lat && (fill == 8'h00);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fill <= 8'h00;
			rd_on <= 1'b0;
			cnt_at_rd <= 8'h00;
			ovf <= 1'b0;
			udf <= 1'b0;
		end else if (rst_q) begin
			fill <= 8'h00;
			rd_on <= 1'b0;
			cnt_at_rd <= 8'h00;
			ovf <= ovf_set;
			udf <= udf_set;
		end else begin
			if (!rd_on && (fill >= HALF)) begin
				rd_on <= 1'b1;
				cnt_at_rd <= lmfc;
			end
			if (wr_lat && !rd_on) begin
				if (fill == DEPTH) ovf <= 1'b1;
				else fill <= fill + 8'h01;
			end else if (rd_on && !wr_lat) begin
				if (fill == 8'h00) udf <= 1'b1;
				else fill <= fill - 8'h01;
			end
		end
	end

	// Interrupt request follows the sticky prbs, eof, eomf and symbol loss flags or any field mismatch
	assign next_irq = sticky[4] | sticky[2] | sticky[1] | sticky[0] | mismatch[15];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) irq_q <= 1'b0;
		else irq_q <= next_irq;
	end
	assign irq = irq_q;
	assign status = {1'b0, irq_q, sticky};

	// Read mux; unmapped indices read zero
	assign rd_mux =
		(lnk.cfg_addr == `DEV_CMD) ? {14'h0000, gate, 1'b0} :
		(lnk.cfg_addr == `DEV_LANE) ? lane_r :
		(lnk.cfg_addr == `DEV_FRAME) ? frame_r :
		(lnk.cfg_addr == `DEV_IDS) ? ids_r :
		(lnk.cfg_addr == `DEV_LINK) ? link_r :
		(lnk.cfg_addr == `DEV_RATE) ? rate_r :
		(lnk.cfg_addr == `DEV_HIGH_SPEED_SERIAL_CLOCK) ? hs_r :
		(lnk.cfg_addr == `DEV_STATUS) ? {8'h00, status} :
		(lnk.cfg_addr == `DEV_MISMATCH) ? mismatch :
		(lnk.cfg_addr == `DEV_ERR) ? {udf, ovf, 5'h00, cfg_err} :
		(lnk.cfg_addr == `DEV_LATENCY) ? {cnt_at_rd, fill} : 16'h0000;

	// Read answer one cycle after the request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata <= 16'h0000;
			rvalid <= 1'b0;
		end else begin
			rvalid <= lnk.cfg_rd;
			if (lnk.cfg_rd) rdata <= rd_mux;
		end
	end
	assign lnk.cfg_rdata = rdata;
	assign lnk.cfg_rvalid = rvalid;
endmodule

// File: core/dfr_pkg.sv
// Bring-up state type used by the baseband end of the deframer pair.
// No state of its own.
package dfr_pkg;
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_SYNC = 3'b001,
		H_RESET = 3'b010,
		H_SREF = 3'b011,
		H_DELAY = 3'b100,
		H_ILAS = 3'b101,
		H_DATA = 3'b110
	} host_state_t;
endpackage

// File: core/dfr_regs.svh
// Register indices, field slices, limits and timing counts for the deframer pair.
// Included by both ends; holds definitions only.
`ifndef DFR_REGS_SVH
`define DFR_REGS_SVH
// Device register indices
`define DEV_CMD 4'h0
`define DEV_LANE 4'h1
`define DEV_FRAME 4'h2
`define DEV_IDS 4'h3
`define DEV_LINK 4'h4
`define DEV_RATE 4'h5
`define DEV_HIGH_SPEED_SERIAL_CLOCK 4'h6
`define DEV_STATUS 4'h8
`define DEV_MISMATCH 4'h9
`define DEV_ERR 4'ha
`define DEV_LATENCY 4'hb
// Write masks keep reserved bits at zero, except bit 5 in LINK_WMASK
`define LANE_WMASK 16'h07ff
`define FRAME_WMASK 16'h3f07
`define IDS_WMASK 16'h0fff
`define LINK_WMASK 16'h1fbf
// Field slices
`define CMD_RESET 0
`define CMD_GATE 1
`define F_MASK 3:0
`define F_INV 7:4
`define F_EQ 10:8
`define F_M 2:0
`define F_K 13:8
`define F_DID 7:0
`define F_BID 11:8
`define F_LID 4:0
`define F_SCR 7
`define F_OFS 12:8
// Limits; rates in 100 kbps, clocks in 100 kHz
`define RATE_MIN 16'h1800
`define RATE_MAX 16'hf000
`define HIGH_SPEED_SERIAL_CLOCK_MAX 16'hf000
`define K_MAX 6'h20
`define FK_MIN 10'h014
`define FK_MAX 10'h100
`define EQ_MAX 3'h4
// Fixed ILAS values and checksum index
`define ILAS_NM1 8'h0f
`define ILAS_NPM1 8'h0f
`define ILAS_CK 4'he
// Host APB byte offsets
`define H_CTRL 8'h00
`define H_PROXY 8'h04
`define H_PROXY_RD 8'h08
`define H_STAT 8'h0c
`define H_DELAY 8'h20
`define H_RATE 8'h24
`define H_ILAS_HI 4'h1
// Host bring-up command and timing counts
`define CMD_BRINGUP 16'h0003
`define SYNC_CYCLES 16'h0010
`define SREF_GAP 16'h0002
`define SREF_END 16'h0005
`endif

// File: core/lane_link_if.sv
// Link between the baseband processor end and the deframer end.
// Both ends run on the same pclk; all signals are synchronous to it.
`timescale 1ns/100ps
interface lane_link_if;
	logic cfg_wr;
	logic cfg_rd;
	logic [3:0] cfg_addr;
	logic [15:0] cfg_wdata;
	logic [15:0] cfg_rdata;
	logic cfg_rvalid;
	logic sysref;
	logic lane_data_valid;
	logic ilas_active;
	logic ilas_stb;
	logic [3:0] ilas_idx;
	logic [7:0] ilas_val;
	logic err_prbs;
	logic err_eof;
	logic err_eomf;
	logic err_fs;
	modport dev (
		input cfg_wr, cfg_rd, cfg_addr, cfg_wdata, sysref, lane_data_valid,
		input ilas_active, ilas_stb, ilas_idx, ilas_val, err_prbs, err_eof, err_eomf, err_fs,
		output cfg_rdata, cfg_rvalid
	);
	modport host (
		output cfg_wr, cfg_rd, cfg_addr, cfg_wdata, sysref, lane_data_valid,
		output ilas_active, ilas_stb, ilas_idx, ilas_val, err_prbs, err_eof, err_eomf, err_fs,
		input cfg_rdata, cfg_rvalid
	);
endinterface

// File: dv/lane_link_properties.sv
// Link checks for the deframer pair: register answers and status byte contents.
// Sees the shared link signals only; instantiated beside the interface.
`timescale 1ns/100ps
`include "dfr_regs.svh"
module lane_link_properties (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Register port
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [3:0] cfg_addr,
	input wire logic [15:0] cfg_wdata,
	input wire logic [15:0] cfg_rdata,
	input wire logic cfg_rvalid,
	// Link events
	input wire logic sysref,
	input wire logic ilas_active,
	input wire logic err_prbs,
	input wire logic err_eof,
	input wire logic err_eomf,
	input wire logic err_fs
);
	logic gate_q;
	logic gated_q;
	logic [3:0] rd_idx;
	logic [5:0] st;
	logic clr_q;
	// Reset command and gated SYSREF rise as the device should see them
	wire logic clr = cfg_wr && cfg_addr == `DEV_CMD && cfg_wdata[`CMD_RESET];
	wire logic rise = sysref && gate_q && !gated_q;
	wire logic [5:0] sets = {rise, err_prbs, 1'b0, err_eof && ilas_active, err_eomf && ilas_active, err_fs};
	wire logic stat_rv = cfg_rvalid && rd_idx == `DEV_STATUS;
	// Reference sticky bits; the clear lands a cycle after the command and a set then survives it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_q <= 1'b0;
			gated_q <= 1'b0;
			rd_idx <= 4'h0;
			st <= 6'h00;
			clr_q <= 1'b0;
		end else begin
			clr_q <= clr;
			gate_q <= (cfg_wr && cfg_addr == `DEV_CMD) ? cfg_wdata[`CMD_GATE] : gate_q;
			gated_q <= sysref && gate_q;
			rd_idx <= cfg_rd ? cfg_addr : rd_idx;
			st <= (clr_q ? 6'h00 : st) | sets;
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_read_answer: assert property (cfg_rd |=> cfg_rvalid)
		else $error("read not answered");
	a_stray_answer: assert property (cfg_rvalid |-> $past(cfg_rd))
		else $error("answer without read");
	a_status_unused: assert property (stat_rv |-> cfg_rdata[15:7] == 9'h000)
		else $error("unused status bits set");
	a_status_irq: assert property (stat_rv && (cfg_rdata[4] || cfg_rdata[2:0] != 3'h0) |-> cfg_rdata[6])
		else $error("interrupt bit missing");
	a_sysref_seen: assert property (stat_rv |-> cfg_rdata[5] == st[5])
		else $error("SYSREF bit wrong");
	a_prbs_error: assert property (stat_rv |-> cfg_rdata[4] == st[4])
		else $error("sequence error bit wrong");
	a_ilas_framing: assert property (stat_rv |-> cfg_rdata[2:1] == st[2:1])
		else $error("framing bits wrong");
	a_symbol_loss: assert property (stat_rv |-> cfg_rdata[0] == st[0])
		else $error("symbol loss bit wrong");
	a_mismatch_or: assert property (cfg_rvalid && rd_idx == `DEV_MISMATCH |->
		cfg_rdata[15] == (cfg_rdata[14:0] != 15'h0000)) else $error("mismatch summary wrong");
	a_sysref_retime: assert property (clr && cfg_wdata[`CMD_GATE] |-> ##[1:16] $rose(sysref))
		else $error("no SYSREF after reset");
	c_status_read: cover property (stat_rv && cfg_rdata[5]);
	c_gated_sysref: cover property (rise);
	c_mismatch_seen: cover property (cfg_rvalid && rd_idx == `DEV_MISMATCH && cfg_rdata[15]);
endmodule

// File: dv/serial_lane_deframer_control_tb_top.sv
// Bench: both ends joined by the link, APB traffic into the baseband end.
// Assumes the designer's register map and pclk at 10 MHz.
`timescale 1ns/100ps
`include "dfr_regs.svh"
module serial_lane_deframer_control_tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, r;
	logic pready, pslverr, link_up, lane_fifo_clear, cfg_ok, irq, e;
	logic [3:0] lane_en, lane_inv;
	logic [2:0] eq_level;
	logic [15:0] lane_w, ids_w, link_w, q, s;
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;
	int clears = 0;
	int bad;
	// Settings tried one at a time and the error bits each must raise (zero means legal)
	logic [3:0] t_idx [13] = '{`DEV_RATE, `DEV_RATE, `DEV_RATE, `DEV_RATE, `DEV_HIGH_SPEED_SERIAL_CLOCK, `DEV_HIGH_SPEED_SERIAL_CLOCK, `DEV_LANE,
		`DEV_LANE, `DEV_LANE, `DEV_FRAME, `DEV_FRAME, `DEV_FRAME, `DEV_FRAME};
	logic [15:0] t_val [13] = '{16'h3000, 16'h17ff, 16'hf001, 16'h1800, 16'hf001, 16'h7000, 16'h0501, 16'h0007,
		16'h0401, 16'h2003, 16'h2102, 16'h0502, 16'h0802};
	logic [8:0] t_err [13] = '{9'h000, 9'h040, 9'h040, 9'h000, 9'h080, 9'h100, 9'h004, 9'h002, 9'h000, 9'h001,
		9'h008, 9'h010, 9'h020};
	lane_link_if lnk ();
	deframer_ctl #(.LAT_DEPTH(8)) deframer_ctl_inst (.pclk(pclk), .presetn(presetn), .lnk(lnk.dev),
		.lane_en(lane_en), .lane_inv(lane_inv), .eq_level(eq_level), .lane_fifo_clear(lane_fifo_clear),
		.cfg_ok(cfg_ok), .irq(irq));
	baseband_ctl baseband_ctl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.lnk(lnk.host), .link_up(link_up));
	lane_link_properties link_checks (.pclk(pclk), .presetn(presetn), .cfg_wr(lnk.cfg_wr), .cfg_rd(lnk.cfg_rd),
		.cfg_addr(lnk.cfg_addr), .cfg_wdata(lnk.cfg_wdata), .cfg_rdata(lnk.cfg_rdata), .cfg_rvalid(lnk.cfg_rvalid),
		.sysref(lnk.sysref), .ilas_active(lnk.ilas_active), .err_prbs(lnk.err_prbs), .err_eof(lnk.err_eof),
		.err_eomf(lnk.err_eomf), .err_fs(lnk.err_fs));
	always #50 pclk = ~pclk;
	// Watchdog and count of deframer reset pulses; one-cycle pulse is seen at exactly one edge
	always @(posedge pclk) begin
		cycles++;
		clears += (lane_fifo_clear === 1'b1);
		if (cycles == 40000) begin
			err_count++;
			end_of_test();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		if (err_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// One APB transfer; an idle edge first keeps psel from being driven twice in a time step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Device register access through the proxy, polled until no longer busy
	task automatic proxy(input logic [3:0] idx, input logic [15:0] d, input logic rdreq);
		apb(1'b1, `H_PROXY, {10'h000, rdreq, !rdreq, idx, d});
		r = 32'h80000000;
		while (r[31] !== 1'b0) apb(1'b0, `H_PROXY_RD, 32'h0);
		q = r[15:0];
	endtask
	task automatic rd(input logic [3:0] idx);
		proxy(idx, 16'h0000, 1'b1);
	endtask
	task automatic cfg_base();
		proxy(`DEV_LANE, lane_w, 1'b0);
		proxy(`DEV_FRAME, 16'h2002, 1'b0);
		proxy(`DEV_IDS, ids_w, 1'b0);
		proxy(`DEV_LINK, link_w, 1'b0);
		proxy(`DEV_RATE, 16'h3000, 1'b0);
		proxy(`DEV_HIGH_SPEED_SERIAL_CLOCK, 16'h6000, 1'b0);
	endtask
	// ILAS field expected for two converters on one lane: F=4, K=32
	function automatic logic [7:0] ilas_exp(input int n);
		case (n)
			0: return ids_w[7:0];
			1: return {4'h0, ids_w[11:8]};
			2: return {3'h0, link_w[4:0]};
			4: return {7'h00, link_w[7]};
			5: return 8'h03;
			6: return 8'h1f;
			7: return 8'h01;
			8: return `ILAS_NM1;
			10: return `ILAS_NPM1;
			default: return 8'h00;
		endcase
	endfunction
	// Load ILAS bytes (one field inverted if bad is 0..13) and start the link; the baseband end
	// sends its own checksum of what it sends, so only the inverted field mismatches
	task automatic bring_up(input int bad_field);
		logic [7:0] b [16];
		logic [7:0] sum;
		sum = 8'h00;
		for (int n = 0; n < 16; n++) begin
			b[n] = ilas_exp(n);
			sum += (n < 14) ? b[n] : 8'h00;
		end
		b[14] = sum;
		if (bad_field >= 0) b[bad_field] = ~b[bad_field];
		for (int w = 0; w < 4; w++) apb(1'b1, 8'h10 + 8'(4 * w), {b[4*w+3], b[4*w+2], b[4*w+1], b[4*w]});
		apb(1'b1, `H_DELAY, 32'($urandom_range(15)));
		apb(1'b1, `H_RATE, 32'h00003000);
		apb(1'b1, `H_CTRL, 32'h00000001);
		while (link_up !== 1'b1) @(posedge pclk);
	endtask
	initial begin
		void'($urandom(17));
		repeat (16) @(posedge pclk);
		check("reset outputs", {lane_en, lane_inv, eq_level, lane_fifo_clear, cfg_ok, irq, link_up}, 32'h0);
		presetn <= 1'b1;
		apb(1'b0, 8'h28, 32'h0);
		check("unmapped error", e, 32'h1);
		check("unmapped data", r, 32'h0);
		for (int i = 0; i < 4; i++) begin
			lane_w = {5'h00, 3'($urandom_range(4)), 4'($urandom), 4'((1 << (1 << $urandom_range(2))) - 1)};
			proxy(`DEV_LANE, lane_w, 1'b0);
			check("lane pins", {lane_en, lane_inv, eq_level}, {lane_w[3:0], lane_w[7:4], lane_w[10:8]});
			rd(`DEV_LANE);
			check("lane readback", q, lane_w);
		end
		lane_w = 16'h0001;
		ids_w = 16'($urandom) & 16'h0fff;
		link_w = 16'h1480 | 16'($urandom_range(31));
		for (int i = 0; i < 13; i++) begin
			cfg_base();
			proxy(t_idx[i], t_val[i], 1'b0);
			rd(`DEV_ERR);
			check("error bits", q[8:0] & (t_err[i] == 9'h0 ? 9'h1ff : t_err[i]), t_err[i]);
			check("settings accepted", cfg_ok, t_err[i] == 9'h000);
		end
		cfg_base();
		clears = 0;
		bring_up(-1);
		check("reset pulses", clears, 1);
		rd(`DEV_STATUS);
		check("status", q, 16'h0028);
		rd(`DEV_MISMATCH);
		check("mismatch", q, 16'h0000);
		rd(`DEV_LATENCY);
		check("latency range", q[15:8] < 8'h20 && q[7:0] >= 8'h04 && q[7:0] <= 8'h08, 1);
		s = 16'h0028;
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, `H_CTRL, 32'h1 | (32'h80 >> k));
			s |= (k == 0) ? 16'h0050 : (k == 3) ? 16'h0041 : 16'h0000;
			rd(`DEV_STATUS);
			check("status after error", q, s);
			check("irq", irq, s[6]);
		end
		proxy(`DEV_CMD, 16'h0001, 1'b0);
		// The pulse is counted at the edge the proxy returns on; let that count settle first
		@(posedge pclk);
		check("reset pulses", clears, 2);
		rd(`DEV_STATUS);
		check("status after reset", q, 16'h0000);
		rd(`DEV_LATENCY);
		check("latency after reset", q, 16'h0000);
		check("irq", irq, 1'b0);
		apb(1'b1, `H_CTRL, 32'h0);
		bad = $urandom_range(13);
		bring_up(bad);
		rd(`DEV_MISMATCH);
		check("mismatch", q, 16'h8000 | (16'h0001 << bad));
		rd(`DEV_STATUS);
		check("status bad ILAS", q, 16'h0068);
		end_of_test();
	end
endmodule
